// >>> design/lbx_top.sv
// Second-link extra lane enable with a Wishbone register slave
`timescale 1ns/10ps
module lbx_top (
  input wire logic clk_i, // Clock, 20 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [31:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic wb_err_o, // Wishbone error on unmapped address
  output lbx_pkg::lbx_lanes_t lanes_o, // Per-lane clock and serializer enables
  output lbx_pkg::lbx_fmt_t fmt_o, // Lane rate and format for all lanes
  output logic subsys_on_o // Serial link subsystem, PLL and LMFC power
);
  import lbx_pkg::*;

  logic [7:0] ctrl_r;
  logic [3:0] mode_r;
  logic [3:0] test_r;
  logic enc_en_r;
  logic pd_a_r;
  logic pd_b_r;
  logic [7:0] used;
  logic req;
  logic hit_ctrl;
  logic hit_cfg;
  logic hit_stat;
  logic [7:0] clk_nxt;
  logic [7:0] ser_nxt;
  logic [7:0] chain;
  logic link_on;
  logic [31:0] rd_nxt;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

  always_comb begin
    hit_ctrl = 1'b0;
    hit_cfg = 1'b0;
    hit_stat = 1'b0;
    if (wb_adr_i == LBX_CTRL_ADDR) begin
      hit_ctrl = 1'b1;
    end else if (wb_adr_i == LBX_CFG_ADDR) begin
      hit_cfg = 1'b1;
    end else if (wb_adr_i == LBX_STAT_ADDR) begin
      hit_stat = 1'b1;
    end
  end

  // Control writes are dropped while the encoder runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= LBX_CTRL_RST;
    end else if (req && wb_we_i && hit_ctrl && wb_sel_i[0] && !enc_en_r) begin
      ctrl_r <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enc_en_r <= 1'b0;
      pd_a_r <= 1'b0;
      pd_b_r <= 1'b0;
      mode_r <= LBX_MODE_RST;
      test_r <= LBX_TEST_RST;
    end else if (req && wb_we_i && hit_cfg) begin
      if (wb_sel_i[0]) begin
        enc_en_r <= wb_dat_i[LBX_CFG_ENC_BIT];
        pd_a_r <= wb_dat_i[LBX_CFG_PDA_BIT];
        pd_b_r <= wb_dat_i[LBX_CFG_PDB_BIT];
      end
      if (wb_sel_i[1]) begin
        mode_r <= wb_dat_i[LBX_CFG_MODE_LSB +: 4];
        test_r <= wb_dat_i[LBX_CFG_TEST_LSB +: 4];
      end
    end
  end

  lbx_mode_lanes u_mode (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .mode_i (mode_r),
    .used_o (used)
  );

  // Second link needs channel B and any live channel for the subsystem
  assign link_on = enc_en_r && !pd_b_r;

  genvar g;
  generate
    for (g = 0; g < LBX_LANES; g++) begin : g_lane
      logic want;
      if (g == 0) begin : g_base
        assign want = used[g];
        assign chain[g] = want;
      end else begin : g_extra
        assign want = used[g] || ctrl_r[g];
        assign chain[g] = want && chain[g-1];
      end
      assign clk_nxt[g] = link_on && want;
      if (g == 0) begin : g_ser0
        assign ser_nxt[g] = link_on && used[g];
      end else begin : g_sern
        assign ser_nxt[g] = link_on && chain[g] && (used[g] || ctrl_r[LBX_SER_SEL_BIT]);
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lanes_o <= '0;
      subsys_on_o <= 1'b0;
    end else begin
      lanes_o.clk_en <= clk_nxt;
      lanes_o.ser_en <= ser_nxt;
      subsys_on_o <= !(pd_a_r && pd_b_r);
    end
  end

  // Format is global, never from the extra-lane register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fmt_o <= '0;
    end else begin
      fmt_o.mode <= mode_r;
      fmt_o.test <= test_r;
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_nxt[7:0] = ctrl_r;
    end else if (hit_cfg) begin
      rd_nxt[LBX_CFG_ENC_BIT] = enc_en_r;
      rd_nxt[LBX_CFG_PDA_BIT] = pd_a_r;
      rd_nxt[LBX_CFG_PDB_BIT] = pd_b_r;
      rd_nxt[LBX_CFG_MODE_LSB +: 4] = mode_r;
      rd_nxt[LBX_CFG_TEST_LSB +: 4] = test_r;
    end else if (hit_stat) begin
      rd_nxt[7:0] = lanes_o.clk_en;
      rd_nxt[15:8] = lanes_o.ser_en;
      rd_nxt[16] = subsys_on_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && (hit_ctrl || hit_cfg || hit_stat);
      wb_err_o <= req && !(hit_ctrl || hit_cfg || hit_stat);
      wb_dat_o <= (req && !wb_we_i) ? rd_nxt : 32'h0000_0000;
    end
  end

  ctrl_locked_a: assert property (@(posedge clk_i) disable iff (rst_i)
    enc_en_r |=> $stable(ctrl_r)) else $error("extra-lane register changed while encoder on");
  ser_chain_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lanes_o.ser_en[3] |-> lanes_o.clk_en[2] && lanes_o.clk_en[1]) else $error("serializer clock chain broken");
  ser_needs_link_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(pd_b_r) |-> lanes_o == '0) else $error("lanes active with channel down");
  ser_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(!ctrl_r[0]) && $past(used) == 8'h01) |-> lanes_o.ser_en[7:1] == 7'h00)
    else $error("extra serializer on without select");
  clk_follows_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(link_on) && $past(ctrl_r[5])) |-> lanes_o.clk_en[5]) else $error("requested lane clock off");
  unused_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(!ctrl_r[6]) && $past(!used[6])) |-> !lanes_o.clk_en[6] && !lanes_o.ser_en[6])
    else $error("unrequested lane active");
  subsys_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pd_a_r && pd_b_r) ##1 (pd_a_r && pd_b_r) |-> !subsys_on_o) else $error("subsystem on with both down");
  fmt_global_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fmt_o.mode == $past(mode_r)) else $error("lane format not from mode");
  reg_reset_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> ctrl_r == LBX_CTRL_RST) else $error("control not zero after reset");

  // Bus handshake, per-lane, subsystem power and format consistency checks
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  ack_err_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wb_ack_o && wb_err_o))
    else $error("acknowledge and error together");
  rd_idle_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside acknowledge");
  ack_mapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && (hit_ctrl || hit_cfg || hit_stat)) |=> wb_ack_o)
    else $error("mapped request not acknowledged");
  err_unmapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !(hit_ctrl || hit_cfg || hit_stat)) |=> wb_err_o)
    else $error("unmapped request without error");
  ctrl_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && hit_ctrl && wb_sel_i[0] && !enc_en_r) |=> ctrl_r == $past(wb_dat_i[7:0]))
    else $error("extra-lane register write lost");
  ser_has_clk_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (lanes_o.ser_en & ~lanes_o.clk_en) == 8'h00)
    else $error("serializer on without lane clock");
  link_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(!link_on) |-> lanes_o == '0)
    else $error("lanes active with link off");
  ser_needs_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(!used[4]) && $past(!ctrl_r[LBX_SER_SEL_BIT])) |-> !lanes_o.ser_en[4])
    else $error("extra serializer on without select");
  subsys_live_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i) && $past(!pd_a_r)) |-> subsys_on_o)
    else $error("subsystem off with channel live");
  fmt_test_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fmt_o.test == $past(test_r))
    else $error("lane format not from test setting");
endmodule // lbx_top

// >>> design/lbx_pkg.sv
// Package for the second-link extra-lane enable block
package lbx_pkg;
  localparam int LBX_LANES = 8;
  localparam logic [31:0] LBX_CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] LBX_CFG_ADDR = 32'h0000_0004;
  localparam logic [31:0] LBX_STAT_ADDR = 32'h0000_0008;
  localparam logic [7:0] LBX_CTRL_RST = 8'h00;
  localparam int LBX_SER_SEL_BIT = 0;
  localparam int LBX_REQ_LSB = 1;
  localparam int LBX_REQ_MSB = 7;
  localparam int LBX_CFG_MODE_LSB = 8;
  localparam int LBX_CFG_TEST_LSB = 12;
  localparam int LBX_CFG_ENC_BIT = 0;
  localparam int LBX_CFG_PDA_BIT = 1;
  localparam int LBX_CFG_PDB_BIT = 2;
  localparam logic [3:0] LBX_MODE_RST = 4'h0;
  localparam logic [3:0] LBX_TEST_RST = 4'h0;

  typedef struct packed {
    logic [3:0] mode;
    logic [3:0] test;
  } lbx_fmt_t;

  typedef struct packed {
    logic [7:0] clk_en;
    logic [7:0] ser_en;
  } lbx_lanes_t;
endpackage

// >>> design/lbx_mode_lanes.sv
// Lanes the selected link mode uses on the second link
`timescale 1ns/10ps
module lbx_mode_lanes (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [3:0] mode_i, // Link mode select
  output logic [7:0] used_o // Registered used-lane mask
);
  import lbx_pkg::*;

  logic [7:0] used_nxt;

  always_comb begin
    used_nxt = 8'h00;
    case (mode_i[1:0])
      2'h0: used_nxt = 8'h01;
      2'h1: used_nxt = 8'h03;
      2'h2: used_nxt = 8'h0f;
      default: used_nxt = 8'hff;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      used_o <= 8'h00;
    end else begin
      used_o <= used_nxt;
    end
  end
endmodule // lbx_mode_lanes

// >>> verification/lbx_rx_model.sv
// Far-side receiver model that sees which lanes carry data
`timescale 1ns/10ps
module lbx_rx_model (
  input wire logic clk_i, // Clock
  input wire lbx_pkg::lbx_lanes_t lanes_i, // Lane enables from the block
  output logic [7:0] live_o // Lanes seen carrying data
);
  import lbx_pkg::*;
  // A lane carries data only with both its clock and its serializer on
  always_ff @(posedge clk_i) begin
    live_o <= lanes_i.clk_en & lanes_i.ser_en;
  end
endmodule // lbx_rx_model

// >>> verification/lbx_top_bench.sv
// Self-checking bench for the second-link extra lane enable block
`timescale 1ns/10ps
module lbx_top_bench;
  import lbx_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, err, subsys, e;
  logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, q;
  logic [7:0] live, ctrl;
  logic [15:0] cfg;
  lbx_lanes_t lanes, x;
  lbx_fmt_t fmt;
  int bad_count = 0, num_checks = 0;
  always #25 clk_i = ~clk_i;
  lbx_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .lanes_o(lanes),
    .fmt_o(fmt), .subsys_on_o(subsys));
  lbx_rx_model rx (.clk_i(clk_i), .lanes_i(lanes), .live_o(live));
  function automatic lbx_lanes_t expect_lanes(logic [7:0] c, logic [15:0] g);
    logic [7:0] used, w, s;
    lbx_lanes_t r;
    used = 8'hff >> (8 - (1 << g[9:8]));
    w = used | {c[7:1], 1'b0};
    s = used | ({c[7:1], 1'b0} & {8{c[0]}});
    r.clk_en = (g[0] && !g[2]) ? w : 8'h00;
    for (int n = 0; n < 8; n++) r.ser_en[n] = r.clk_en[n] & s[n] & (&(w | ~((8'h02 << n) - 8'h01)));
    return r;
  endfunction
  task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) bad_count++;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(50 * 5000);
    bad_count++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h753a));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    wb(1'b0, LBX_CTRL_ADDR, 32'h0);
    chk("ctrl reset", q, {24'h0, LBX_CTRL_RST});
    wb(1'b0, 32'h0000_000c, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 14; i++) begin
      ctrl = (i == 0) ? 8'hfe : (i == 1) ? 8'h0b : 8'($urandom);
      cfg = (i < 2) ? 16'h0001 : (16'($urandom) | 16'h0001);
      wb(1'b1, LBX_CFG_ADDR, 32'h0);
      wb(1'b1, LBX_CTRL_ADDR, {24'h0, ctrl});
      wb(1'b1, LBX_CFG_ADDR, {16'h0, cfg});
      // Encoder now on, so this write must be ignored
      wb(1'b1, LBX_CTRL_ADDR, {24'h0, ~ctrl});
      repeat (4) @(posedge clk_i);
      x = expect_lanes(ctrl, cfg);
      wb(1'b0, LBX_CTRL_ADDR, 32'h0);
      chk("ctrl", q, {24'h0, ctrl});
      chk("lanes", {16'h0, lanes}, {16'h0, x});
      chk("fmt", {24'h0, fmt}, {24'h0, cfg[11:8], cfg[15:12]});
      chk("subsys", {31'h0, subsys}, {31'h0, ~(cfg[1] & cfg[2])});
      wb(1'b0, LBX_STAT_ADDR, 32'h0);
      chk("status", {15'h0, q[16:0]}, {15'h0, ~(cfg[1] & cfg[2]), x.ser_en, x.clk_en});
      chk("rx live", {24'h0, live}, {24'h0, x.ser_en});
      $display("test %0d done", i);
    end
    report_and_stop;
  end
endmodule // lbx_top_bench
